/* asc_core.sv */
// security erase, freeze, disable and smart decode with ahb-lite regs
// assumes one ahb-lite master, word transfers, hard reset on a pin
`timescale 1ns/1ns
`default_nettype none
module asc_core (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hard_resetn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic o_erase_pulse,
   output logic o_smart_go,
   output logic [10:0] o_smart_sel,
   output logic o_frozen
);
   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   asc_pkg::asc_state_t state_r;
   asc_pkg::asc_cmd_t cmd_in;
   asc_pkg::asc_status_t status;
   logic [7:0] addr_r;
   logic wr_r, pend_r;
   logic wr_cyc, rd_cyc, cmd_acc, data_acc;
   logic hrst_meta_r, hrst_sync_r;
   logic frozen_r, armed_r, lock_en_r, locked_r, expired_r;
   logic err_r, done_r, op_erase_r;
   logic [7:0] word_cnt_r;
   logic [7:0] smart_code_r;
   logic [10:0] smart_hit;
   logic user_eq, mast_eq, ident, sel_match;
   logic [15:0] st_user, st_mast;
   logic frz_cmd, go_xfer, abort_now;

   // -----------------------------------------------------------
   // ahb-lite slave, one wait state per transfer
   // -----------------------------------------------------------
   // the wait state lets read data come from a flop
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pend_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 8'h00;
         o_hreadyout <= 1'b1;
      end else if (pend_r) begin
         pend_r <= 1'b0;
         o_hreadyout <= 1'b1;
      end else if (i_hsel && i_htrans[1] && i_hready) begin
         pend_r <= 1'b1;
         wr_r <= i_hwrite;
         addr_r <= i_haddr[7:0];
         o_hreadyout <= 1'b0;
      end
   end

   // only okay responses; size is taken as a full word
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_hresp <= 1'b0;
      end else begin
         o_hresp <= asc_pkg::HRESP_OKAY[0];
      end
   end

   assign wr_cyc = pend_r && wr_r;
   assign rd_cyc = pend_r && !wr_r;
   assign cmd_in = i_hwdata[15:0];
   // new commands only while idle; a write while busy is dropped
   assign cmd_acc = wr_cyc && addr_r == asc_pkg::OFS_CMD && state_r == asc_pkg::ST_IDLE;
   assign data_acc = wr_cyc && addr_r == asc_pkg::OFS_DATA && state_r == asc_pkg::ST_XFER;

   // status word gathered for reads
   always_comb begin
      status = '0;
      status.word_cnt = word_cnt_r;
      status.expired = expired_r;
      status.locked = locked_r;
      status.lock_en = lock_en_r;
      status.armed = armed_r;
      status.frozen = frozen_r;
      status.done = done_r;
      status.err = err_r;
      status.drq = state_r == asc_pkg::ST_XFER;
      status.busy = state_r != asc_pkg::ST_IDLE;
   end

   // read mux, unmapped offsets return zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_hrdata <= asc_pkg::RD_ZERO;
      end else if (rd_cyc) begin
         if (addr_r == asc_pkg::OFS_STATUS) begin
            o_hrdata <= status;
         end else if (addr_r == asc_pkg::OFS_CTRL) begin
            o_hrdata <= {29'h0000_0000, expired_r, locked_r, lock_en_r};
         end else if (addr_r == asc_pkg::OFS_SMART) begin
            o_hrdata <= {24'h00_0000, smart_code_r};
         end else begin
            o_hrdata <= asc_pkg::RD_ZERO;
         end
      end
   end

   // -----------------------------------------------------------
   // hard reset pin synchroniser
   // -----------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         hrst_meta_r <= 1'b1;
         hrst_sync_r <= 1'b1;
      end else begin
         hrst_meta_r <= i_hard_resetn;
         hrst_sync_r <= hrst_meta_r;
      end
   end

   // -----------------------------------------------------------
   // command decode
   // -----------------------------------------------------------
   // commands that touch the lock functions are refused when frozen
   assign frz_cmd = cmd_in.code == asc_pkg::CMD_SET_PW || cmd_in.code == asc_pkg::CMD_UNLOCK
      || cmd_in.code == asc_pkg::CMD_DISABLE || cmd_in.code == asc_pkg::CMD_PREP
      || cmd_in.code == asc_pkg::CMD_ERASE;

   always_comb begin
      abort_now = 1'b0;
      go_xfer = 1'b0;
      if (frozen_r && frz_cmd) begin
         abort_now = 1'b1;
      end else if (cmd_in.code == asc_pkg::CMD_ERASE) begin
         abort_now = !armed_r || expired_r;
         go_xfer = armed_r && !expired_r;
      end else if (cmd_in.code == asc_pkg::CMD_UNLOCK) begin
         abort_now = expired_r;
      end else if (cmd_in.code == asc_pkg::CMD_DISABLE) begin
         abort_now = locked_r;
         go_xfer = !locked_r;
      end else if (cmd_in.code == asc_pkg::CMD_SMART) begin
         abort_now = smart_hit == 11'h000;
      end
   end

   // one comparator per smart subcommand code
   for (genvar g = 0; g < asc_pkg::SMART_N; g++) begin : g_smart
      assign smart_hit[g] = cmd_in.feature == asc_pkg::SMART_CODE[g];
   end

   // -----------------------------------------------------------
   // command state machine
   // -----------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         state_r <= asc_pkg::ST_IDLE;
      end else begin
         case (state_r)
            asc_pkg::ST_IDLE: begin
               if (cmd_acc && go_xfer) begin
                  state_r <= asc_pkg::ST_XFER;
               end
            end
            asc_pkg::ST_XFER: begin
               if (data_acc && word_cnt_r == asc_pkg::WORD_LAST) begin
                  state_r <= asc_pkg::ST_EXEC;
               end
            end
            asc_pkg::ST_EXEC: begin
               state_r <= asc_pkg::ST_IDLE;
            end
            default: begin
               state_r <= asc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // payload word counter, one sector of 256 words
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || cmd_acc) begin
         word_cnt_r <= 8'h00;
      end else if (data_acc) begin
         word_cnt_r <= word_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         op_erase_r <= 1'b0;
      end else if (cmd_acc) begin
         op_erase_r <= cmd_in.code == asc_pkg::CMD_ERASE;
      end
   end

   // erase honours the identifier, disable accepts either password
   assign sel_match = ident ? mast_eq : user_eq;

   // completion and error flags, reloaded when the next command lands
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         err_r <= 1'b0;
         done_r <= 1'b0;
      end else if (cmd_acc) begin
         err_r <= abort_now;
         done_r <= !go_xfer || abort_now;
      end else if (state_r == asc_pkg::ST_EXEC) begin
         done_r <= 1'b1;
         err_r <= op_erase_r ? !sel_match : !(user_eq || mast_eq);
      end
   end

   // -----------------------------------------------------------
   // security state flags
   // -----------------------------------------------------------
   // frozen survives everything but power-on and hard reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !hrst_sync_r) begin
         frozen_r <= 1'b0;
      end else if (cmd_acc && cmd_in.code == asc_pkg::CMD_FREEZE) begin
         frozen_r <= 1'b1;
      end
   end

   // armed only by a prepare that was not refused
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         armed_r <= 1'b0;
      end else if (cmd_acc) begin
         armed_r <= cmd_in.code == asc_pkg::CMD_PREP && !abort_now;
      end
   end

   // expiry is reported by firmware, held until a reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !hrst_sync_r) begin
         expired_r <= 1'b0;
      end else if (wr_cyc && addr_r == asc_pkg::OFS_CTRL && i_hwdata[asc_pkg::CTRL_EXPIRED]) begin
         expired_r <= 1'b1;
      end
   end

   // lock flags: software set wins over a same-cycle hardware clear
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         lock_en_r <= 1'b0;
         locked_r <= 1'b0;
      end else if (wr_cyc && addr_r == asc_pkg::OFS_CTRL) begin
         lock_en_r <= i_hwdata[asc_pkg::CTRL_LOCK_EN];
         locked_r <= i_hwdata[asc_pkg::CTRL_LOCKED];
      end else if (state_r == asc_pkg::ST_EXEC) begin
         if (op_erase_r && sel_match) begin
            lock_en_r <= 1'b0;
            locked_r <= 1'b0;
         end else if (!op_erase_r && (user_eq || mast_eq)) begin
            lock_en_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_erase_pulse <= 1'b0;
      end else begin
         o_erase_pulse <= state_r == asc_pkg::ST_EXEC && op_erase_r && sel_match;
      end
   end

   // subcommand latched from the feature byte at issue time
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_smart_go <= 1'b0;
         o_smart_sel <= 11'h000;
         smart_code_r <= 8'h00;
      end else begin
         o_smart_go <= 1'b0;
         if (cmd_acc && cmd_in.code == asc_pkg::CMD_SMART && smart_hit != 11'h000) begin
            o_smart_go <= 1'b1;
            o_smart_sel <= smart_hit;
            smart_code_r <= cmd_in.feature;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_frozen <= 1'b0;
      end else begin
         o_frozen <= frozen_r;
      end
   end

   // -----------------------------------------------------------
   // password store and comparator
   // -----------------------------------------------------------
   // master store is written only by the load register
   asc_pwstore u_store (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_wr(wr_cyc && addr_r == asc_pkg::OFS_PWLOAD),
      .i_master(i_hwdata[asc_pkg::PWL_MASTER]),
      .i_widx(i_hwdata[asc_pkg::PWL_IDX_LSB +: 4]),
      .i_wdata(i_hwdata[15:0]),
      .i_ridx(word_cnt_r[3:0] - 4'h1),
      .o_user(st_user),
      .o_master(st_mast)
   );

   asc_pwcmp u_cmp (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_clear(cmd_acc),
      .i_valid(data_acc),
      .i_idx(word_cnt_r),
      .i_data(i_hwdata[15:0]),
      .i_user(st_user),
      .i_master(st_mast),
      .o_user_eq(user_eq),
      .o_mast_eq(mast_eq),
      .o_ident(ident)
   );

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_issue(logic [7:0] c);
      cmd_acc && cmd_in.code == c;
   endsequence

   sequence s_exec_erase;
      state_r == asc_pkg::ST_EXEC && op_erase_r;
   endsequence

   AST_ERASE_UNARMED: assert property (
      s_issue(asc_pkg::CMD_ERASE) and !armed_r |=> err_r && state_r == asc_pkg::ST_IDLE)
      else $error("erase without prepare not aborted");
   AST_ERASE_XFER: assert property (
      s_issue(asc_pkg::CMD_ERASE) and armed_r && !frozen_r && !expired_r
      |=> status.drq && word_cnt_r == 8'h00)
      else $error("erase did not request payload");
   AST_ERASE_BAD_PW: assert property (
      s_exec_erase and !sel_match |=> err_r && !o_erase_pulse)
      else $error("erase mismatch not aborted");
   AST_ERASE_GOOD: assert property (
      s_exec_erase and sel_match |=> o_erase_pulse ##1 !o_erase_pulse)
      else $error("erase pulse missing or long");
   AST_FREEZE: assert property (
      s_issue(asc_pkg::CMD_FREEZE) and hrst_sync_r |=> frozen_r && done_r && !err_r)
      else $error("freeze did not set frozen");
   AST_FROZEN_REJECT: assert property (
      cmd_acc && frozen_r && frz_cmd |=> err_r && state_r == asc_pkg::ST_IDLE)
      else $error("frozen command accepted");
   AST_FROZEN_HOLD: assert property (
      frozen_r && hrst_sync_r |=> frozen_r)
      else $error("frozen dropped without reset");
   AST_DISABLE_LOCKED: assert property (
      s_issue(asc_pkg::CMD_DISABLE) and locked_r |=> err_r && !status.busy)
      else $error("disable accepted while locked");
   AST_SMART_D5: assert property (
      s_issue(asc_pkg::CMD_SMART) and cmd_in.feature == 8'hD5
      |=> o_smart_go && o_smart_sel[5] ##1 !o_smart_go)
      else $error("smart read log not decoded");
   AST_EXPIRED: assert property (
      s_issue(asc_pkg::CMD_ERASE) and expired_r |=> err_r)
      else $error("erase taken with expired counter");
endmodule // asc_core
`default_nettype wire

/* asc_host_model.sv */
// host adapter model: single-word ahb-lite master for the command block
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/1ns
`default_nettype none
module asc_host_model (
   input wire logic i_ref_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   // ---------------------------------------------------------------
   // bus idle at time zero
   // ---------------------------------------------------------------
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0000_0000;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = 3'h2;
      o_hwdata = 32'h0000_0000;
   end
   // one transfer; no wait count assumed, only the bench watchdog ends a hang
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge i_ref_clk);
      o_hsel <= 1'b1;
      o_htrans <= 2'h2;
      o_haddr <= {24'h00_0000, a};
      o_hwrite <= wr;
      o_hsize <= 3'h2;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      o_hsel <= 1'b0;
      o_htrans <= 2'h0;
      o_haddr <= ~{24'h00_0000, a}; // released address shows no stale value
      o_hwdata <= wd;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      rd = i_hrdata;
      o_hwdata <= ~wd; // released data shows no stale value
   endtask
endmodule // asc_host_model
`default_nettype wire

/* asc_pkg.sv */
// constants and carrier types for the security and smart command block
// assumes a 32-bit ahb-lite register bus and 16-bit host data words
package asc_pkg;
   // -----------------------------------------------------------
   // command codes
   // -----------------------------------------------------------
   localparam logic [7:0] CMD_SET_PW = 8'hF1;
   localparam logic [7:0] CMD_UNLOCK = 8'hF2;
   localparam logic [7:0] CMD_PREP = 8'hF3;
   localparam logic [7:0] CMD_ERASE = 8'hF4;
   localparam logic [7:0] CMD_FREEZE = 8'hF5;
   localparam logic [7:0] CMD_DISABLE = 8'hF6;
   localparam logic [7:0] CMD_SMART = 8'hB0;
   localparam int SMART_N = 11;
   // smart subcommand codes, entry 0 is read attribute values
   localparam logic [SMART_N-1:0][7:0] SMART_CODE = {
      8'hDB, 8'hDA, 8'hD9, 8'hD8, 8'hD6, 8'hD5,
      8'hD4, 8'hD3, 8'hD2, 8'hD1, 8'hD0};
   // -----------------------------------------------------------
   // payload sector layout
   // -----------------------------------------------------------
   localparam logic [7:0] WORD_LAST = 8'hFF;
   localparam logic [7:0] PW_FIRST = 8'h01;
   localparam logic [7:0] PW_LAST = 8'h10;
   localparam int PW_WORDS = 16;
   localparam int IDENT_BIT = 0;
   // -----------------------------------------------------------
   // register map, byte addresses
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;
   localparam logic [7:0] OFS_PWLOAD = 8'h10;
   localparam logic [7:0] OFS_SMART = 8'h14;
   localparam int CTRL_LOCK_EN = 0;
   localparam int CTRL_LOCKED = 1;
   localparam int CTRL_EXPIRED = 2;
   localparam int PWL_MASTER = 20;
   localparam int PWL_IDX_LSB = 16;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef struct packed {
      logic [7:0] feature;
      logic [7:0] code;
   } asc_cmd_t;
   typedef struct packed {
      logic [14:0] rsvd;
      logic [7:0] word_cnt;
      logic expired;
      logic locked;
      logic lock_en;
      logic armed;
      logic frozen;
      logic done;
      logic err;
      logic drq;
      logic busy;
   } asc_status_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_EXEC = 3'b100
   } asc_state_t;
endpackage

/* asc_pwcmp.sv */
// running comparison of a received payload against stored passwords
// assumes words arrive in order 0..255 with their index
`timescale 1ns/1ns
`default_nettype none
module asc_pwcmp (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_clear,
   input wire logic i_valid,
   input wire logic [7:0] i_idx,
   input wire logic [15:0] i_data,
   input wire logic [15:0] i_user,
   input wire logic [15:0] i_master,
   output logic o_user_eq,
   output logic o_mast_eq,
   output logic o_ident
);
   logic in_pw;

   // words 1..16 carry the password, the rest but word 0 are ignored
   assign in_pw = i_idx >= asc_pkg::PW_FIRST && i_idx <= asc_pkg::PW_LAST;

   // -----------------------------------------------------------
   // match flags start true and drop on any differing word
   // -----------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || i_clear) begin
         o_user_eq <= 1'b1;
         o_mast_eq <= 1'b1;
      end else if (i_valid && in_pw) begin
         o_user_eq <= o_user_eq && (i_data == i_user);
         o_mast_eq <= o_mast_eq && (i_data == i_master);
      end
   end

   // identifier: bit 0 of the control word, reserved bits unused
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || i_clear) begin
         o_ident <= 1'b0;
      end else if (i_valid && i_idx == 8'h00) begin
         o_ident <= i_data[asc_pkg::IDENT_BIT];
      end
   end
endmodule // asc_pwcmp
`default_nettype wire

/* asc_pwstore.sv */
// stored user and master passwords, sixteen words each
// assumes writes come from the register slave on the same clock
`timescale 1ns/1ns
`default_nettype none
module asc_pwstore (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic i_master,
   input wire logic [3:0] i_widx,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_ridx,
   output logic [15:0] o_user,
   output logic [15:0] o_master
);
   logic [15:0] user_mem [asc_pkg::PW_WORDS];
   logic [15:0] mast_mem [asc_pkg::PW_WORDS];

   // -----------------------------------------------------------
   // storage, one entry per word
   // -----------------------------------------------------------
   // only the load port writes here: erase and disable keep master
   for (genvar g = 0; g < asc_pkg::PW_WORDS; g++) begin : g_word
      always_ff @(posedge i_ref_clk) begin
         if (!i_resetn) begin
            user_mem[g] <= 16'h0000;
            mast_mem[g] <= 16'h0000;
         end else if (i_wr && i_widx == 4'(g)) begin
            if (i_master) begin
               mast_mem[g] <= i_wdata;
            end else begin
               user_mem[g] <= i_wdata;
            end
         end
      end
   end

   // read ports follow the payload word index
   assign o_user = user_mem[i_ridx];
   assign o_master = mast_mem[i_ridx];
endmodule // asc_pwstore
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the security and smart command block
// assumes the host model drives the bus and the bench reads status back
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic hard_resetn = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, erase_pulse, smart_go, frozen;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [10:0] smart_sel;
   int n_errors = 0;
   int cmp_count = 0;
   int n_erase = 0;
   int n_go = 0;
   always #25 ref_clk = ~ref_clk;
   asc_core dut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_hard_resetn(hard_resetn),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .o_hrdata(hrdata), .o_erase_pulse(erase_pulse), .o_smart_go(smart_go),
      .o_smart_sel(smart_sel), .o_frozen(frozen));
   asc_host_model host (.i_ref_clk(ref_clk), .i_hready(hreadyout), .i_hrdata(hrdata),
      .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
      .o_hwdata(hwdata));
   // pulse counters, pulses last one cycle so each edge is looked at
   always @(posedge ref_clk) begin
      if (erase_pulse === 1'b1) n_erase <= n_erase + 1;
      if (smart_go === 1'b1) n_go <= n_go + 1;
   end
   // ---------------------------------------------------------------
   // bus and command helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      host.xfer(1'b1, a, d, x);
   endtask
   task automatic rdr(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0000_0000, rd);
   endtask
   // non-transfer command, then error and done flags from status
   task automatic cmd(input logic [7:0] c, input logic [7:0] f, input logic e);
      asc_pkg::asc_status_t s;
      wr(asc_pkg::OFS_CMD, {16'h0000, f, c});
      rdr(asc_pkg::OFS_STATUS);
      s = asc_pkg::asc_status_t'(rd);
      `CHK("cmd_err", e, s.err)
      `CHK("cmd_done", 1'b1, s.done)
      `CHK("cmd_hresp", 1'b0, hresp)
   endtask
   // one payload sector: control word, 16 password words, reserved zeros
   task automatic sector(input logic id, input logic [15:0] base, input logic e);
      asc_pkg::asc_status_t s;
      rdr(asc_pkg::OFS_STATUS);
      s = asc_pkg::asc_status_t'(rd);
      `CHK("drq_on", 1'b1, s.drq)
      for (int i = 0; i < 256; i++)
         wr(asc_pkg::OFS_DATA, {16'h0000, (i == 0) ? {15'h0000, id} :
            ((i <= 16) ? base + 16'(i) : 16'h0000)});
      for (int k = 0; k < 8 && s.done !== 1'b1; k++) begin
         rdr(asc_pkg::OFS_STATUS);
         s = asc_pkg::asc_status_t'(rd);
      end
      `CHK("sec_done", 1'b1, s.done)
      `CHK("sec_err", e, s.err)
      `CHK("drq_off", 1'b0, s.drq)
   endtask
   task automatic load(input logic m, input logic [15:0] base);
      for (int j = 0; j < 16; j++)
         wr(asc_pkg::OFS_PWLOAD, {11'h000, m, 4'(j), base + 16'(j + 1)});
   endtask
   task automatic hard_rst;
      @(posedge ref_clk);
      hard_resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      hard_resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_erase;
      wr(asc_pkg::OFS_CTRL, 32'h0000_0003);
      cmd(asc_pkg::CMD_ERASE, 8'h00, 1'b1);
      cmd(asc_pkg::CMD_PREP, 8'h00, 1'b0);
      cmd(asc_pkg::CMD_SMART, 8'hD0, 1'b0);
      cmd(asc_pkg::CMD_ERASE, 8'h00, 1'b1);
      cmd(asc_pkg::CMD_PREP, 8'h00, 1'b0);
      wr(asc_pkg::OFS_CMD, {24'h00_0000, asc_pkg::CMD_ERASE});
      sector(1'b1, 16'hA000, 1'b1);
      `CHK("no_erase", 0, n_erase)
      cmd(asc_pkg::CMD_PREP, 8'h00, 1'b0);
      wr(asc_pkg::OFS_CMD, {24'h00_0000, asc_pkg::CMD_ERASE});
      sector(1'b0, 16'hA000, 1'b0);
      `CHK("erase_cnt", 1, n_erase)
      rdr(asc_pkg::OFS_CTRL);
      `CHK("lock_off", 2'h0, rd[1:0])
   endtask
   task automatic t_disable;
      wr(asc_pkg::OFS_CTRL, 32'h0000_0003);
      cmd(asc_pkg::CMD_DISABLE, 8'h00, 1'b1);
      wr(asc_pkg::OFS_CTRL, 32'h0000_0001);
      wr(asc_pkg::OFS_CMD, {24'h00_0000, asc_pkg::CMD_DISABLE});
      sector(1'b0, 16'hC000, 1'b1);
      rdr(asc_pkg::OFS_CTRL);
      `CHK("lock_kept", 1'b1, rd[0])
      wr(asc_pkg::OFS_CMD, {24'h00_0000, asc_pkg::CMD_DISABLE});
      sector(1'b0, 16'hB000, 1'b0);
      rdr(asc_pkg::OFS_CTRL);
      `CHK("lock_gone", 1'b0, rd[0])
   endtask
   task automatic t_smart;
      int g0;
      // earlier scenarios also issue smart commands, so count from here
      g0 = n_go;
      for (int i = 0; i < asc_pkg::SMART_N; i++) begin
         cmd(asc_pkg::CMD_SMART, asc_pkg::SMART_CODE[i], 1'b0);
         `CHK("smart_sel", 11'(1 << i), smart_sel)
      end
      `CHK("smart_go", asc_pkg::SMART_N, n_go - g0)
      cmd(asc_pkg::CMD_SMART, 8'hD7, 1'b1);
      rdr(asc_pkg::OFS_SMART);
      `CHK("smart_code", 8'hDB, rd[7:0])
      `CHK("smart_go_bad", asc_pkg::SMART_N, n_go - g0)
   endtask
   task automatic t_freeze;
      logic [4:0][7:0] rej;
      rej = {asc_pkg::CMD_SET_PW, asc_pkg::CMD_UNLOCK, asc_pkg::CMD_PREP,
         asc_pkg::CMD_ERASE, asc_pkg::CMD_DISABLE};
      cmd(asc_pkg::CMD_FREEZE, 8'h00, 1'b0);
      `CHK("frozen_on", 1'b1, frozen)
      for (int i = 0; i < 5; i++) cmd(rej[i], 8'h00, 1'b1);
      cmd(asc_pkg::CMD_FREEZE, 8'h00, 1'b0);
      `CHK("frozen_kept", 1'b1, frozen)
      hard_rst();
      `CHK("frozen_off", 1'b0, frozen)
      cmd(asc_pkg::CMD_PREP, 8'h00, 1'b0);
   endtask
   task automatic t_expire;
      wr(asc_pkg::OFS_CTRL, 32'h0000_0004);
      cmd(asc_pkg::CMD_PREP, 8'h00, 1'b0);
      cmd(asc_pkg::CMD_ERASE, 8'h00, 1'b1);
      cmd(asc_pkg::CMD_UNLOCK, 8'h00, 1'b1);
      hard_rst();
      cmd(asc_pkg::CMD_UNLOCK, 8'h00, 1'b0);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog sized well past the longest expected run
   initial begin
      #1000000;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      load(1'b0, 16'hA000);
      load(1'b1, 16'hB000);
      t_erase();
      t_disable();
      t_smart();
      t_freeze();
      t_expire();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
